// *** hw/line_activation_fsm.sv ***
// Layer-1 activation state machine for one line channel, two modes.
`timescale 1ns/1ps
`include "line_act_defines.svh"

module line_activation_fsm
	import line_act_pkg::*;
(
	// Clock and reset.
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Reset pin of the line interface, active low, asynchronous source.
	input  wire logic       line_reset_n_i,
	// Mode and loop selection from software.
	input  wire logic       exchange_side_mode_i,
	input  wire logic       loop_enable_bit_i,
	input  wire logic       external_loop_bit_i,
	// Command mailbox.
	input  wire logic       cmd_valid_i,
	input  wire logic [3:0] cmd_code_i,
	// Receiver status.
	input  wire rx_info_t   rx_info_i,
	input  wire logic       frame_end_i,
	input  wire logic       frame_cv_i,
	input  wire logic       multiframe_end_i,
	input  wire logic       illegal_cv_i,
	// Indications and transmit control.
	output logic [3:0]      ind_code_o,
	output logic            ind_change_o,
	output logic [3:0]      last_cmd_o,
	output tx_sel_t         tx_sel_o,
	output logic            t_bit_o,
	output logic            loop2_req_o,
	output logic            awake_det_en_o,
	output logic            int_loop_o,
	output logic            ext_loop_o
);

	// --------------------------------------------------------------------
	// State registers.
	// --------------------------------------------------------------------
	act_regs_t r_r;
	act_regs_t r_nxt;

	logic       cmd_now;
	logic       pin_reset;
	logic [3:0] ind_new;

	// --------------------------------------------------------------------
	// Next-state logic.
	// --------------------------------------------------------------------
	// The reset pin passes three flops; reset holds while the last two
	// are both low, so a single-cycle glitch cannot reset the channel.
	always_comb begin
		r_nxt = r_r;
		r_nxt.rst_sync = {r_r.rst_sync[1:0], line_reset_n_i};
		pin_reset = (r_r.rst_sync[2:1] == 2'b00);
		cmd_now = cmd_valid_i;
		ind_new = r_r.ind;
		r_nxt.ind_chg = 1'b0;
		if (cmd_now) begin
			r_nxt.last_cmd = cmd_code_i;
		end
		// Running timer, cleared on every state change below.
		if (r_r.tmr != 24'hffffff) begin
			r_nxt.tmr = r_r.tmr + 24'h1;
		end

		// Unconditional commands act from any state.
		if (pin_reset || (cmd_now && cmd_code_i == `CMD_SOFT_RESET)) begin
			r_nxt.state = ST_RESET;
		end else if (cmd_now && cmd_code_i == `CMD_SINGLE_PULSE) begin
			r_nxt.state = ST_TEST1;
		end else if (cmd_now && cmd_code_i == `CMD_CONT_PULSE) begin
			r_nxt.state = ST_TEST2;
		end else if (cmd_now && cmd_code_i == `CMD_DEACT_REQUEST) begin
			r_nxt.state = ST_PEND_DEACT;
			r_nxt.deact_pending = 1'b1;
		end else begin
			unique case (r_r.state)
				// Unconditional states are left only by another unconditional
				// command, the deactivate request among them, handled above.
				ST_RESET, ST_TEST1, ST_TEST2: begin
				end
				ST_PEND_DEACT: begin
					if (cmd_now && cmd_code_i == `CMD_DEACT_CONFIRM) begin
						r_nxt.state = ST_WAIT_DR;
					end else if (rx_info_i != RX_INFO0) begin
						r_nxt.tmr = 24'h0;
					end else if (!exchange_side_mode_i &&
						r_r.tmr >= 24'(`SETTLE_CYC - 1)) begin
						r_nxt.state = ST_WAIT_DR;
					end else if (exchange_side_mode_i) begin
						r_nxt.state = ST_WAIT_DR;
					end
					if (exchange_side_mode_i &&
						r_r.tmr >= 24'(`DEACT_TMR_CYC - 1)) begin
						r_nxt.state = ST_WAIT_DR;
					end
				end
				ST_WAIT_DR, ST_DEACT: begin
					if (cmd_now && cmd_code_i == `CMD_DEACT_CONFIRM) begin
						r_nxt.state = ST_DEACT;
						r_nxt.deact_pending = 1'b0;
					end else if (r_r.state == ST_DEACT ||
						!exchange_side_mode_i) begin
						if (cmd_now && cmd_code_i == `CMD_ACT_REQUEST) begin
							r_nxt.state = ST_PEND_ACT;
						end else if (cmd_now && !exchange_side_mode_i &&
							cmd_code_i == `CMD_LOOP_TWO_ACT) begin
							r_nxt.state = ST_PEND_ACT;
							r_nxt.loop2 = 1'b1;
						end else if (cmd_now && !exchange_side_mode_i &&
							cmd_code_i == `CMD_BLOCKED_ACT) begin
							r_nxt.state = ST_BLOCKED;
						end else if (r_r.state == ST_DEACT &&
							((!exchange_side_mode_i &&
							rx_info_i == RX_INFO1W) ||
							(exchange_side_mode_i &&
							rx_info_i == RX_INFO1))) begin
							r_nxt.state = ST_PEND_ACT;
						end
					end
				end
				ST_PEND_ACT, ST_RESYNC: begin
					if (exchange_side_mode_i) begin
						if (rx_info_i == RX_INFO3) begin
							r_nxt.state = ST_ACTIVE;
						end
					end else if (rx_info_i == RX_INFO1) begin
						r_nxt.state = ST_SYNCED;
					end
				end
				ST_SYNCED: begin
					// Clean frames are counted; a violated one restarts.
					if (frame_end_i) begin
						if (frame_cv_i) begin
							r_nxt.good_frames = 2'h0;
						end else if (r_r.good_frames == 2'h1) begin
							r_nxt.state = ST_ACTIVE;
						end else begin
							r_nxt.good_frames = 2'h1;
						end
					end
				end
				ST_ACTIVE: begin
					if (rx_info_i != RX_INFO3) begin
						r_nxt.state = ST_RESYNC;
					end
				end
				ST_BLOCKED: begin
					if (cmd_now && cmd_code_i == `CMD_DEACT_CONFIRM) begin
						r_nxt.state = ST_DEACT;
					end
				end
				default: r_nxt.state = ST_RESET;
			endcase
		end
		if (r_nxt.state != r_r.state) begin
			r_nxt.tmr = 24'h0;
			r_nxt.good_frames = 2'h0;
			if (r_nxt.state != ST_SYNCED && r_nxt.state != ST_PEND_ACT) begin
				r_nxt.loop2 = 1'b0;
			end
		end
		r_nxt.t_bit = r_nxt.loop2;

		// Code violations are tallied per multiframe, then shown 4 times.
		if (exchange_side_mode_i && illegal_cv_i) begin
			r_nxt.cv_seen = 1'b1;
		end
		if (multiframe_end_i) begin
			if (r_r.cvr_left != 3'h0) begin
				r_nxt.cvr_left = r_r.cvr_left - 3'h1;
			end
			if (r_r.cv_seen || (exchange_side_mode_i && illegal_cv_i)) begin
				r_nxt.cvr_left = 3'(`CVR_REPEAT);
				r_nxt.cv_seen = 1'b0;
			end
		end

		// Indication from the new state.
		unique case (r_nxt.state)
			ST_PEND_ACT: ind_new = (r_nxt.state == r_r.state) ?
				r_r.ind : `IND_ACT_REQUEST;
			ST_SYNCED: ind_new = `IND_LINE_ONLY_ACT;
			ST_RESYNC: ind_new = `IND_RESYNC;
			ST_ACTIVE: ind_new = `IND_ACT_COMPLETE;
			ST_WAIT_DR: ind_new = `IND_DEACT;
			default: ind_new = `IND_TIMING;
		endcase
		if (exchange_side_mode_i && r_nxt.cvr_left != 3'h0 &&
			r_nxt.state == ST_ACTIVE) begin
			ind_new = `IND_CODE_VIOLATION;
		end
		r_nxt.ind = ind_new;
		r_nxt.ind_chg = (ind_new != r_r.ind);
	end

	// --------------------------------------------------------------------
	// Register stage.
	// --------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			r_r <= '{state: ST_RESET, rst_sync: 3'h7, default: '0};
		end else begin
			r_r <= r_nxt;
		end
	end

	// --------------------------------------------------------------------
	// Outputs.
	// --------------------------------------------------------------------
	// Transmit choice follows the registered state only.
	always_comb begin
		unique case (r_r.state)
			ST_TEST1: tx_sel_o = TX_PULSE_1;
			ST_TEST2: tx_sel_o = TX_PULSE_2;
			ST_PEND_ACT, ST_SYNCED, ST_RESYNC: tx_sel_o = TX_INFO2;
			ST_ACTIVE, ST_BLOCKED: tx_sel_o = TX_INFO4;
			default: tx_sel_o = TX_INFO0;
		endcase
	end
	assign awake_det_en_o = (r_r.state != ST_RESET) &&
		(r_r.state != ST_TEST1) && (r_r.state != ST_TEST2);
	assign ind_code_o = r_r.ind;
	assign ind_change_o = r_r.ind_chg;
	assign last_cmd_o = r_r.last_cmd;
	assign t_bit_o = r_r.t_bit;
	assign loop2_req_o = r_r.loop2;
	assign int_loop_o = loop_enable_bit_i && !external_loop_bit_i;
	assign ext_loop_o = loop_enable_bit_i && external_loop_bit_i;

endmodule : line_activation_fsm

// *** hw/line_act_defines.svh ***
// Command, indication and timing constants for the line activation machines.
`ifndef LINE_ACT_DEFINES_SVH
`define LINE_ACT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Command codes.
// ----------------------------------------------------------------------------
`define CMD_DEACT_REQUEST   4'h0
`define CMD_SOFT_RESET      4'h1
`define CMD_SINGLE_PULSE    4'h2
`define CMD_CONT_PULSE      4'h3
`define CMD_ACT_REQUEST     4'h8
`define CMD_LOOP_TWO_ACT    4'ha
`define CMD_BLOCKED_ACT     4'hc
`define CMD_DEACT_CONFIRM   4'hf

// ----------------------------------------------------------------------------
// Indication codes.
// ----------------------------------------------------------------------------
`define IND_TIMING          4'h0
`define IND_RESYNC          4'h4
`define IND_ACT_REQUEST     4'h8
`define IND_LINE_ONLY_ACT   4'h7
`define IND_CODE_VIOLATION  4'hb
`define IND_ACT_COMPLETE    4'hc
`define IND_DEACT           4'hf

// ----------------------------------------------------------------------------
// Timing, as printed and as cycle counts at 250 MHz (4 ns).
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS       4
`define SYNC_MAX_MS         10
`define SYNC_MAX_CYC        ((`SYNC_MAX_MS * 1000000) / `CLK_PERIOD_NS)
`define SETTLE_MS           2
`define SETTLE_CYC          ((`SETTLE_MS * 1000000) / `CLK_PERIOD_NS)
`define DEACT_TMR_MS        32
`define DEACT_TMR_CYC       ((`DEACT_TMR_MS * 1000000) / `CLK_PERIOD_NS)
`define CVR_REPEAT          4

`endif

// *** hw/line_act_pkg.sv ***
// Types shared by the line activation machines.
package line_act_pkg;

	// Received line signal classification.
	typedef enum logic [2:0] {
		RX_INFO0  = 3'h0,
		RX_INFO1W = 3'h1,
		RX_INFO1  = 3'h2,
		RX_INFO3  = 3'h3,
		RX_OTHER  = 3'h4
	} rx_info_t;

	// Transmitted signal selection.
	typedef enum logic [2:0] {
		TX_INFO0   = 3'h0,
		TX_INFO2   = 3'h1,
		TX_INFO4   = 3'h2,
		TX_PULSE_1 = 3'h3,
		TX_PULSE_2 = 3'h4
	} tx_sel_t;

	// Machine states for both modes; ST_SYNCED and ST_BLOCKED are entered in the non-exchange mode only.
	typedef enum logic [3:0] {
		ST_RESET      = 4'h0,
		ST_TEST1      = 4'h1,
		ST_TEST2      = 4'h2,
		ST_PEND_DEACT = 4'h3,
		ST_WAIT_DR    = 4'h4,
		ST_DEACT      = 4'h5,
		ST_PEND_ACT   = 4'h6,
		ST_SYNCED     = 4'h7,
		ST_ACTIVE     = 4'h8,
		ST_RESYNC     = 4'h9,
		ST_BLOCKED    = 4'ha
	} act_state_t;

	// Whole state of the block.
	typedef struct packed {
		act_state_t state;
		logic [3:0] last_cmd;
		logic [3:0] ind;
		logic [23:0] tmr;
		logic [1:0] good_frames;
		logic [2:0] cvr_left;
		logic cv_seen;
		logic loop2;
		logic t_bit;
		logic deact_pending;
		logic ind_chg;
		logic [2:0] rst_sync;
	} act_regs_t;

endpackage : line_act_pkg

// *** test/line_act_props.sv ***
// Port checker of the line activation machine, with its bind.
`timescale 1ns/1ps
`include "line_act_defines.svh"

module line_act_props
	import line_act_pkg::*;
(
	// Clock, reset and inputs.
	input wire logic       ref_clk_i,
	input wire logic       rst_i,
	input wire logic       exchange_side_mode_i,
	input wire logic       loop_enable_bit_i,
	input wire logic       external_loop_bit_i,
	input wire logic       cmd_valid_i,
	input wire logic [3:0] cmd_code_i,
	// Outputs of the machine.
	input wire logic [3:0] ind_code_o,
	input wire logic       ind_change_o,
	input wire logic [3:0] last_cmd_o,
	input wire tx_sel_t    tx_sel_o,
	input wire logic       t_bit_o,
	input wire logic       loop2_req_o,
	input wire logic       awake_det_en_o,
	input wire logic       int_loop_o,
	input wire logic       ext_loop_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// Unconditional commands show one cycle after the strobe edge.
	property p_cmd_tx(logic [3:0] c, tx_sel_t t);
		cmd_valid_i && cmd_code_i == c |=> tx_sel_o == t && !awake_det_en_o;
	endproperty
	a_soft_reset: assert property (p_cmd_tx(`CMD_SOFT_RESET, TX_INFO0))
		else $error("soft reset did not silence the line");
	a_test_one: assert property (p_cmd_tx(`CMD_SINGLE_PULSE, TX_PULSE_1))
		else $error("single pulse test not sent");
	a_test_two: assert property (p_cmd_tx(`CMD_CONT_PULSE, TX_PULSE_2))
		else $error("continuous pulse test not sent");

	// Indications and the transmitted signal must agree.
	a_active_info4: assert property (ind_code_o == `IND_ACT_COMPLETE
		|-> tx_sel_o == TX_INFO4) else $error("active without INFO 4");
	a_resync_info2: assert property (ind_code_o == `IND_RESYNC
		|-> tx_sel_o == TX_INFO2) else $error("resync without INFO 2");
	a_line_sync: assert property (!exchange_side_mode_i &&
		ind_code_o == `IND_LINE_ONLY_ACT |-> tx_sel_o == TX_INFO2)
		else $error("synced without INFO 2");
	a_deact_quiet: assert property (ind_code_o == `IND_DEACT
		|-> tx_sel_o == TX_INFO0) else $error("deact with signal on line");

	// Loop selection, T bit and command holding.
	a_loop_t_bit: assert property (t_bit_o |-> loop2_req_o)
		else $error("T bit set without loop two");
	a_loop_route: assert property (int_loop_o ==
		(loop_enable_bit_i && !external_loop_bit_i) &&
		ext_loop_o == (loop_enable_bit_i && external_loop_bit_i))
		else $error("loop routing wrong");
	a_last_cmd: assert property (cmd_valid_i |=>
		last_cmd_o == $past(cmd_code_i)) else $error("command not held");
	a_ind_flag: assert property (ind_change_o == $changed(ind_code_o))
		else $error("indication change flag wrong");

	// Main scenarios reached.
	c_active: cover property (ind_code_o == `IND_ACT_COMPLETE);
	c_viol: cover property (ind_code_o == `IND_CODE_VIOLATION);
	c_test: cover property (tx_sel_o == TX_PULSE_2);
endmodule : line_act_props

bind line_activation_fsm line_act_props u_props (
	.ref_clk_i, .rst_i, .exchange_side_mode_i, .loop_enable_bit_i,
	.external_loop_bit_i, .cmd_valid_i, .cmd_code_i, .ind_code_o,
	.ind_change_o, .last_cmd_o, .tx_sel_o, .t_bit_o, .loop2_req_o,
	.awake_det_en_o, .int_loop_o, .ext_loop_o
);

// *** test/remote_term_model.sv ***
// Behavioural model of the remote terminal transceiver.
`timescale 1ns/1ps

module remote_term_model
	import line_act_pkg::*;
(
	// Clock and scenario controls.
	input  wire logic    ref_clk_i,
	input  wire logic    wake_i,
	input  wire logic    drop_i,
	input  wire tx_sel_t tx_sel_i,
	// Received line status seen by the machine.
	output rx_info_t     rx_info_o,
	output logic         frame_end_o,
	output logic         frame_cv_o
);
	logic [3:0] cnt = 4'h0;
	logic [1:0] ph = 2'h0;

	// Answers INFO 2 with INFO 1 first, then clean INFO 3 frames.
	// Dropping forces an unknown signal so INFO 3 is lost on purpose.
	always @(negedge ref_clk_i) begin
		ph <= ph + 2'h1;
		frame_end_o <= (ph == 2'h3);
		frame_cv_o <= (tx_sel_i == TX_INFO2 && cnt < 4'h8);
		if (tx_sel_i != TX_INFO2 || drop_i)
			cnt <= 4'h0;
		else if (cnt != 4'hf)
			cnt <= cnt + 4'h1;
		if (drop_i)
			rx_info_o <= RX_OTHER;
		else if (tx_sel_i == TX_INFO0)
			rx_info_o <= wake_i ? RX_INFO1W : RX_INFO0;
		else if (tx_sel_i == TX_INFO2)
			rx_info_o <= (cnt < 4'h8) ? RX_INFO1 : RX_INFO3;
		else if (tx_sel_i == TX_INFO4)
			rx_info_o <= RX_INFO3;
		else
			rx_info_o <= RX_INFO0;
	end
endmodule : remote_term_model

// *** test/test_line_activation_fsm.sv ***
// Self-checking bench of the line activation machine.
`timescale 1ns/1ps
`include "line_act_defines.svh"

module test_line_activation_fsm
	import line_act_pkg::*;
;
	logic ref_clk_i = 0, rst_i = 1, line_reset_n_i = 1, cmd_valid_i = 0;
	logic exchange_side_mode_i = 0, loop_enable_bit_i = 0;
	logic external_loop_bit_i = 0, multiframe_end_i = 0, illegal_cv_i = 0;
	logic wake = 0, drop = 0, frame_end_i, frame_cv_i;
	logic [3:0] cmd_code_i = 4'h0, ind_code_o, last_cmd_o;
	logic ind_change_o, t_bit_o, loop2_req_o, awake_det_en_o;
	logic int_loop_o, ext_loop_o;
	rx_info_t rx_info_i;
	tx_sel_t tx_sel_o;
	int n_mismatch = 0, n_checks = 0;

	always #2 ref_clk_i = ~ref_clk_i;

	line_activation_fsm DUT (.ref_clk_i, .rst_i, .line_reset_n_i,
		.exchange_side_mode_i, .loop_enable_bit_i, .external_loop_bit_i,
		.cmd_valid_i, .cmd_code_i, .rx_info_i, .frame_end_i, .frame_cv_i,
		.multiframe_end_i, .illegal_cv_i, .ind_code_o, .ind_change_o,
		.last_cmd_o, .tx_sel_o, .t_bit_o, .loop2_req_o, .awake_det_en_o,
		.int_loop_o, .ext_loop_o);
	remote_term_model u_term (.ref_clk_i, .wake_i(wake), .drop_i(drop),
		.tx_sel_i(tx_sel_o), .rx_info_o(rx_info_i), .frame_end_o(frame_end_i),
		.frame_cv_o(frame_cv_i));

	// ------------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------------
	task end_sim;
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim
	task chk(string n, logic [3:0] e, logic [3:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One strobe cycle; returns at the falling edge after it is taken.
	task cmd(logic [3:0] c);
		@(negedge ref_clk_i);
		cmd_valid_i <= 1;
		cmd_code_i <= c;
		@(negedge ref_clk_i);
		cmd_valid_i <= 0;
	endtask : cmd
	task wait_ind(logic [3:0] e);
		for (int i = 0; i < 400 && ind_code_o !== e; i++)
			@(negedge ref_clk_i);
		chk("ind", e, ind_code_o);
		if (ind_code_o !== e)
			end_sim;
	endtask : wait_ind
	task go_deact;
		cmd(`CMD_DEACT_REQUEST);
		cmd(`CMD_DEACT_CONFIRM);
		wait_ind(`IND_DEACT);
		cmd(`CMD_DEACT_CONFIRM);
		wait_ind(`IND_TIMING);
	endtask : go_deact
	// Illegal violation, if asked, then one multiframe end.
	task mframe(logic v);
		@(negedge ref_clk_i);
		illegal_cv_i <= v;
		@(negedge ref_clk_i);
		illegal_cv_i <= 0;
		multiframe_end_i <= 1;
		@(negedge ref_clk_i);
		multiframe_end_i <= 0;
	endtask : mframe

	// ------------------------------------------------------------------
	// Scenarios.
	// ------------------------------------------------------------------
	task t_loops;
		for (int i = 0; i < 4; i++) begin
			@(negedge ref_clk_i);
			{loop_enable_bit_i, external_loop_bit_i} = i[1:0];
			#1;
			chk("int", i == 2, int_loop_o);
			chk("ext", i == 3, ext_loop_o);
		end
	endtask : t_loops
	task t_tests;
		logic [3:0] cs [3] = '{4'h2, 4'h3, 4'h1};
		tx_sel_t ts [3] = '{TX_PULSE_1, TX_PULSE_2, TX_INFO0};
		for (int i = 0; i < 3; i++) begin
			cmd(cs[i]);
			chk("tx", ts[i], tx_sel_o);
			chk("last", cs[i], last_cmd_o);
			chk("awake", 0, awake_det_en_o);
		end
		go_deact;
	endtask : t_tests
	// Start by command in the non-exchange mode, sync, activation, lost INFO 3 and recovery.
	task t_act;
		cmd(`CMD_ACT_REQUEST);
		chk("ind", `IND_ACT_REQUEST, ind_code_o);
		chk("chg", 1, ind_change_o);
		chk("tx", TX_INFO2, tx_sel_o);
		wait_ind(`IND_LINE_ONLY_ACT);
		wait_ind(`IND_ACT_COMPLETE);
		chk("tx", TX_INFO4, tx_sel_o);
		drop = 1;
		wait_ind(`IND_RESYNC);
		chk("tx", TX_INFO2, tx_sel_o);
		drop = 0;
		wait_ind(`IND_LINE_ONLY_ACT);
		go_deact;
		wake = 1;
		wait_ind(`IND_ACT_REQUEST);
		chk("tx", TX_INFO2, tx_sel_o);
		wake = 0;
		go_deact;
	endtask : t_act
	task t_special;
		cmd(`CMD_LOOP_TWO_ACT);
		chk("tx", TX_INFO2, tx_sel_o);
		chk("t_bit", 1, t_bit_o);
		chk("loop2", 1, loop2_req_o);
		go_deact;
		cmd(`CMD_BLOCKED_ACT);
		chk("tx", TX_INFO4, tx_sel_o);
		chk("t_bit", 0, t_bit_o);
		go_deact;
	endtask : t_special
	// Reset pin held low from the deactivated state, then released.
	task t_pin;
		line_reset_n_i = 0;
		repeat (5) @(negedge ref_clk_i);
		chk("tx", TX_INFO0, tx_sel_o);
		chk("awake", 0, awake_det_en_o);
		line_reset_n_i = 1;
		repeat (4) @(negedge ref_clk_i);
		chk("awake", 0, awake_det_en_o);
		go_deact;
	endtask : t_pin
	task t_exch;
		exchange_side_mode_i = 1;
		cmd(`CMD_ACT_REQUEST);
		chk("tx", TX_INFO2, tx_sel_o);
		wait_ind(`IND_ACT_COMPLETE);
		chk("tx", TX_INFO4, tx_sel_o);
		mframe(1);
		wait_ind(`IND_CODE_VIOLATION);
		repeat (5) mframe(0);
		wait_ind(`IND_ACT_COMPLETE);
		cmd(`CMD_DEACT_REQUEST);
		wait_ind(`IND_DEACT);
		cmd(`CMD_DEACT_CONFIRM);
		wait_ind(`IND_TIMING);
		chk("tx", TX_INFO0, tx_sel_o);
	endtask : t_exch

	// Main sequence: two cycles of reset, then every scenario.
	initial begin
		repeat (2) @(negedge ref_clk_i);
		rst_i = 0;
		chk("ind", `IND_TIMING, ind_code_o);
		chk("tx", TX_INFO0, tx_sel_o);
		t_loops;
		t_tests;
		t_act;
		t_special;
		t_pin;
		t_exch;
		end_sim;
	end
endmodule : test_line_activation_fsm
